// *** rtl/cit_regs.svh ***
// constants for the calibrated interval timer: offsets, reset values, timing counts
// assumes a 10 MHz aclk; included by bare name wherever a constant is needed
`ifndef CIT_REGS_SVH
`define CIT_REGS_SVH

// register byte offsets on the AXI4-Lite slave
`define CIT_ADDR_STATUS 8'h00
`define CIT_ADDR_COUNTS 8'h04
`define CIT_ADDR_MEASURE 8'h08
`define CIT_ADDR_TABLE 8'h20
`define CIT_ADDR_TABLE_END 8'h3c

// status register field positions
`define CIT_ST_PRESS_LSB 0
`define CIT_ST_DEBOUNCE_LSB 8
`define CIT_ST_SELECT_BIT 16
`define CIT_ST_WAITING_BIT 17
`define CIT_ST_LED_BIT 18

// interval table
`define CIT_TABLE_DEPTH 8
`define CIT_TABLE_LAST 8'h07
`define CIT_TABLE0_RST 8'h01
`define CIT_TABLE_STEP_RST 8'h01

// clock and timing
`define CIT_CLK_NS 100
`define CIT_BASE_PERIOD_NS 100000000
`define CIT_MEAS_STEP_CLKS 7
`define CIT_WAKE_NS 27000
`define CIT_WAKE_CLKS 11
`define CIT_WAKE_OFFSET ((`CIT_WAKE_NS + `CIT_WAKE_CLKS * `CIT_CLK_NS) / (`CIT_MEAS_STEP_CLKS * `CIT_CLK_NS))
`define CIT_MEAS_PRELOAD (`CIT_WAKE_OFFSET + 1)
`define CIT_DEBOUNCE_TICKS 8'h09

// tick source: interval tick at 0.75 of an overflow of 2^6 slow-clock periods
`define CIT_WDT_OVF_LOG2 6
`define CIT_TICK_SLOW_PERIODS (((1 << `CIT_WDT_OVF_LOG2) * 3) / 4)
`define CIT_SLOW_DIV_DEFAULT 667

// bus responses
`define CIT_RESP_OKAY 2'b00
`define CIT_RESP_SLVERR 2'b10

`endif

// *** rtl/cit_pkg.sv ***
// types shared by the calibrated interval timer modules
// assumes nothing beyond a SystemVerilog compiler
package cit_pkg;
	typedef enum logic {CIT_SEL_MEASURE, CIT_SEL_COUNT} cit_select_type;
	typedef logic [7:0] cit_byte_type;
	typedef logic [15:0] cit_meas_type;
endpackage : cit_pkg

// *** rtl/cit_tick_source.sv ***
// free-running interval tick generator standing in for the watchdog interval tick
// assumes aclk at 10 MHz; the slow clock is derived by an aclk divider
`timescale 1ns/100ps
`include "cit_regs.svh"
module cit_tick_source #(
	parameter int SLOW_DIV = `CIT_SLOW_DIV_DEFAULT
)
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// tick out
	output logic tick_event
);
	import cit_pkg::*;

	localparam logic [15:0] PRE_LAST = 16'(SLOW_DIV - 1);
	localparam logic [5:0] SLOW_LAST = 6'(`CIT_TICK_SLOW_PERIODS - 1);

	logic [15:0] pre;
	logic [5:0] slow;
	logic next_tick;
	logic [15:0] next_pre;
	logic [5:0] next_slow;

	// no low-power gating exists here: the counter runs on every edge, as a tick must wake a halted system
	always_comb
	begin
		next_pre = pre + 16'h0001;
		next_slow = slow;
		next_tick = 1'b0;
		if (pre == PRE_LAST)
		begin
			next_pre = 16'h0000;
			next_slow = slow + 6'h01;
			if (slow == SLOW_LAST)
			begin
				next_slow = 6'h00;
				next_tick = 1'b1;
			end
		end
	end

	// counting starts at the first edge after reset release
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pre <= 16'h0000;
			slow <= 6'h00;
			tick_event <= 1'b0;
		end
		else
		begin
			pre <= next_pre;
			slow <= next_slow;
			tick_event <= next_tick;
		end
	end

	sequence s_tick_quiet;
		!tick_event [*8];
	endsequence

	chk_tick_spacing: assert property (@(posedge aclk) disable iff (!aresetn)
		tick_event |=> s_tick_quiet)
	else $error("tick pulses too close together");

endmodule : cit_tick_source

// *** rtl/cit_key_filter.sv ***
// key edge detect and tick-counted debounce wait with a press decision at the end
// assumes key_input_pin is synchronous to aclk; tick is gated by the caller
`timescale 1ns/100ps
`include "cit_regs.svh"
module cit_key_filter
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// key side
	input wire logic key_input_pin,
	input wire logic tick,
	// results
	output logic press_now,
	output logic waiting,
	output cit_pkg::cit_byte_type debounce_count
);
	import cit_pkg::*;

	logic key_prev;
	logic key_edge_event;
	logic next_waiting;
	cit_byte_type next_debounce_count;

	assign key_edge_event = key_prev & ~key_input_pin;

	always_comb
	begin
		next_waiting = waiting;
		next_debounce_count = debounce_count;
		press_now = 1'b0;
		if (!waiting)
		begin
			if (key_edge_event)
			begin
				next_debounce_count = `CIT_DEBOUNCE_TICKS;
				next_waiting = 1'b1;
			end
		end
		else if (tick && debounce_count != 8'h00)
		begin
			next_debounce_count = debounce_count - 8'h01;
			if (debounce_count == 8'h01)
			begin
				next_waiting = 1'b0;
				press_now = ~key_input_pin;
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			key_prev <= 1'b1;
			waiting <= 1'b0;
			debounce_count <= 8'h00;
		end
		else
		begin
			key_prev <= key_input_pin;
			waiting <= next_waiting;
			debounce_count <= next_debounce_count;
		end
	end

	chk_debounce_load: assert property (@(posedge aclk) disable iff (!aresetn)
		(key_edge_event && !waiting) |=> (waiting && debounce_count == `CIT_DEBOUNCE_TICKS))
	else $error("debounce wait not loaded on key edge");

	chk_no_early_sample: assert property (@(posedge aclk) disable iff (!aresetn)
		(debounce_count > 8'h01) |-> !press_now)
	else $error("key sampled before debounce wait ended");

	chk_release_high: assert property (@(posedge aclk) disable iff (!aresetn)
		key_input_pin |-> !press_now)
	else $error("press taken with key pin high");

endmodule : cit_key_filter

// *** rtl/cit_timer.sv ***
// calibrated interval timer with AXI4-Lite status and interval table access
// assumes aclk at 10 MHz, synchronous active-low reset, key pin synchronous to aclk
// Operation
// - sample key pin at the ninth counting-path tick following a key edge; measurement ticks are not counted
// - while debounce count nonzero, skip key sampling and just count
// - debounce done and pin low: press accepted, press counter increments
// - debounce done and pin high: no press, counter unchanged
// - press counter past last table index wraps to zero
// - each counting tick decrements base count; at zero decrement interval
// - interval at zero: reload from table, toggle LED, recalibrate next
// - base period start preloads measure counter with offset plus one
// - wake offset is 40 from 27us plus 11 clocks over 7-clock steps
// - measurement tick converts measure count to ticks nearest 100ms
// - after loading calibration, decrement base once, then resume counting
// - handler selects measurement at base start, counting while in progress
// - tick source runs from reset release, tick at 0.75 of 2^6 slow periods
// - tick source keeps running in low-power states
// - debounce, press, base, interval counters and table entries are 8 bits
// - key falling edge loads nine and ignores edges until wait ends
// - after reset press counter zero and first table entry is one
//
// Design decisions made here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/100ps
`include "cit_regs.svh"
module cit_timer #(
	parameter int SLOW_DIV = `CIT_SLOW_DIV_DEFAULT
)
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// key and indicator
	input wire logic key_input_pin,
	output logic led_drive
);
	import cit_pkg::*;

	localparam logic [15:0] WAKE_PRELOAD = 16'(`CIT_MEAS_PRELOAD);
	localparam logic [2:0] STEP_LAST = 3'(`CIT_MEAS_STEP_CLKS - 1);
	localparam logic [31:0] STEP_NS = 32'(`CIT_MEAS_STEP_CLKS * `CIT_CLK_NS);

	cit_byte_type interval_table [`CIT_TABLE_DEPTH];
	cit_byte_type next_table [`CIT_TABLE_DEPTH];
	cit_byte_type press_count, base_period_count, interval_count, calibrated;
	cit_byte_type next_press, next_base, next_interval, next_calibrated;
	cit_meas_type measure_counter, last_measure, next_measure, next_last_measure;
	logic [2:0] step, next_step;
	cit_select_type tick_handler_select, next_select;
	logic next_led;
	logic tick_event;
	logic debounce_tick;
	logic press_now;
	logic waiting;
	cit_byte_type debounce_count;
	cit_byte_type calc_ticks;

	// ticks nearest the base period: rounded quotient, clamped to a usable 8-bit count
	function automatic cit_byte_type ticks_for(input cit_meas_type meas);
		logic [31:0] den;
		logic [31:0] q;
		den = 32'(meas) * STEP_NS;
		if (den == 32'h0000_0000)
			den = 32'h0000_0001;
		q = (32'(`CIT_BASE_PERIOD_NS) + (den >> 1)) / den;
		if (q > 32'h0000_00ff)
			ticks_for = 8'hff;
		else if (q == 32'h0000_0000)
			ticks_for = 8'h01;
		else
			ticks_for = q[7:0];
	endfunction : ticks_for

	// table offsets share one decode between the read and write paths
	function automatic logic is_table(input logic [7:0] addr);
		is_table = (addr >= `CIT_ADDR_TABLE) && (addr <= `CIT_ADDR_TABLE_END) && (addr[1:0] == 2'b00);
	endfunction : is_table

	cit_tick_source #(
		.SLOW_DIV(SLOW_DIV)
	) u_tick (
		.aclk(aclk),
		.aresetn(aresetn),
		.tick_event(tick_event)
	);

	// the key filter only sees ticks handled by the counting path
	assign debounce_tick = tick_event && (tick_handler_select == CIT_SEL_COUNT);

	cit_key_filter u_key (
		.aclk(aclk),
		.aresetn(aresetn),
		.key_input_pin(key_input_pin),
		.tick(debounce_tick),
		.press_now(press_now),
		.waiting(waiting),
		.debounce_count(debounce_count)
	);

	assign calc_ticks = ticks_for(measure_counter);

	// core timing group
	always_comb
	begin
		next_press = press_count;
		next_base = base_period_count;
		next_interval = interval_count;
		next_calibrated = calibrated;
		next_measure = measure_counter;
		next_last_measure = last_measure;
		next_step = step;
		next_select = tick_handler_select;
		next_led = led_drive;
		if (tick_handler_select == CIT_SEL_MEASURE)
		begin
			// one measure step per seven clocks, saturating so a stalled tick cannot wrap
			next_step = (step == STEP_LAST) ? 3'h0 : step + 3'h1;
			if (step == STEP_LAST && measure_counter != 16'hffff)
				next_measure = measure_counter + 16'h0001;
			if (tick_event)
			begin
				next_calibrated = calc_ticks;
				next_last_measure = measure_counter;
				next_base = calc_ticks - 8'h01;
				next_select = CIT_SEL_COUNT;
			end
		end
		else if (tick_event)
		begin
			if (press_now)
				next_press = (press_count >= `CIT_TABLE_LAST) ? 8'h00 : press_count + 8'h01;
			if (base_period_count <= 8'h01)
			begin
				next_interval = interval_count - 8'h01;
				if (interval_count <= 8'h01)
				begin
					next_interval = interval_table[next_press[2:0]];
					next_led = ~led_drive;
					next_select = CIT_SEL_MEASURE;
					next_measure = WAKE_PRELOAD;
					next_step = 3'h0;
					next_base = 8'h00;
				end
				else
				begin
					next_base = calibrated;
				end
			end
			else
			begin
				next_base = base_period_count - 8'h01;
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			press_count <= 8'h00;
			base_period_count <= 8'h00;
			interval_count <= `CIT_TABLE0_RST;
			calibrated <= 8'h01;
			measure_counter <= WAKE_PRELOAD;
			last_measure <= 16'h0000;
			step <= 3'h0;
			tick_handler_select <= CIT_SEL_MEASURE;
			led_drive <= 1'b0;
		end
		else
		begin
			press_count <= next_press;
			base_period_count <= next_base;
			interval_count <= next_interval;
			calibrated <= next_calibrated;
			measure_counter <= next_measure;
			last_measure <= next_last_measure;
			step <= next_step;
			tick_handler_select <= next_select;
			led_drive <= next_led;
		end
	end

	// bus group: address and data are taken in either order, answered once both are held
	logic aw_have, w_have, next_aw_have, next_w_have;
	logic [7:0] aw_addr, next_aw_addr;
	logic [31:0] w_data, next_w_data, next_rdata;
	logic [3:0] w_strb, next_w_strb;
	logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
	logic [1:0] next_bresp, next_rresp;
	logic [31:0] rd_value;
	logic rd_ok;

	always_comb
	begin
		rd_ok = 1'b1;
		rd_value = 32'h0000_0000;
		if (s_axi_araddr == `CIT_ADDR_STATUS)
		begin
			rd_value[`CIT_ST_PRESS_LSB +: 8] = press_count;
			rd_value[`CIT_ST_DEBOUNCE_LSB +: 8] = debounce_count;
			rd_value[`CIT_ST_SELECT_BIT] = (tick_handler_select == CIT_SEL_MEASURE);
			rd_value[`CIT_ST_WAITING_BIT] = waiting;
			rd_value[`CIT_ST_LED_BIT] = led_drive;
		end
		else if (s_axi_araddr == `CIT_ADDR_COUNTS)
			rd_value = {8'h00, calibrated, interval_count, base_period_count};
		else if (s_axi_araddr == `CIT_ADDR_MEASURE)
			rd_value = {16'h0000, last_measure};
		else if (is_table(s_axi_araddr))
			rd_value = {24'h00_0000, interval_table[s_axi_araddr[4:2]]};
		else
			rd_ok = 1'b0;
	end

	always_comb
	begin
		next_aw_have = aw_have;
		next_w_have = w_have;
		next_aw_addr = aw_addr;
		next_w_data = w_data;
		next_w_strb = w_strb;
		next_bvalid = s_axi_bvalid;
		next_bresp = s_axi_bresp;
		next_arready = s_axi_arready;
		next_rvalid = s_axi_rvalid;
		next_rdata = s_axi_rdata;
		next_rresp = s_axi_rresp;
		for (int i = 0; i < `CIT_TABLE_DEPTH; i++)
			next_table[i] = interval_table[i];
		if (s_axi_awvalid && s_axi_awready)
		begin
			next_aw_have = 1'b1;
			next_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			next_w_have = 1'b1;
			next_w_data = s_axi_wdata;
			next_w_strb = s_axi_wstrb;
		end
		if (s_axi_bvalid && s_axi_bready)
			next_bvalid = 1'b0;
		if (aw_have && w_have && !s_axi_bvalid)
		begin
			next_aw_have = 1'b0;
			next_w_have = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = `CIT_RESP_OKAY;
			// only the table is writable; other mapped words ignore writes
			if (is_table(aw_addr))
			begin
				if (w_strb[0])
					next_table[aw_addr[4:2]] = w_data[7:0];
			end
			else if (aw_addr != `CIT_ADDR_STATUS && aw_addr != `CIT_ADDR_COUNTS && aw_addr != `CIT_ADDR_MEASURE)
				next_bresp = `CIT_RESP_SLVERR;
		end
		if (s_axi_arvalid && s_axi_arready)
		begin
			next_arready = 1'b0;
			next_rvalid = 1'b1;
			next_rdata = rd_value;
			next_rresp = rd_ok ? `CIT_RESP_OKAY : `CIT_RESP_SLVERR;
		end
		else if (s_axi_rvalid && s_axi_rready)
		begin
			next_rvalid = 1'b0;
			next_arready = 1'b1;
		end
		next_awready = !next_aw_have;
		next_wready = !next_w_have;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_have <= 1'b0;
			w_have <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `CIT_RESP_OKAY;
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `CIT_RESP_OKAY;
			interval_table[0] <= `CIT_TABLE0_RST;
			for (int i = 1; i < `CIT_TABLE_DEPTH; i++)
				interval_table[i] <= 8'(i + 1);
		end
		else
		begin
			aw_have <= next_aw_have;
			w_have <= next_w_have;
			aw_addr <= next_aw_addr;
			w_data <= next_w_data;
			w_strb <= next_w_strb;
			s_axi_awready <= next_awready;
			s_axi_wready <= next_wready;
			s_axi_bvalid <= next_bvalid;
			s_axi_bresp <= next_bresp;
			s_axi_arready <= next_arready;
			s_axi_rvalid <= next_rvalid;
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= next_rresp;
			for (int i = 0; i < `CIT_TABLE_DEPTH; i++)
				interval_table[i] <= next_table[i];
		end
	end

	sequence s_meas_tick;
		tick_event && tick_handler_select == CIT_SEL_MEASURE;
	endsequence

	chk_measure_resume: assert property (@(posedge aclk) disable iff (!aresetn)
		s_meas_tick |=> (tick_handler_select == CIT_SEL_COUNT && base_period_count == $past(calc_ticks) - 8'h01))
	else $error("calibration not loaded and decremented");

	chk_base_countdown: assert property (@(posedge aclk) disable iff (!aresetn)
		(tick_event && tick_handler_select == CIT_SEL_COUNT && base_period_count > 8'h01)
		|=> (base_period_count == $past(base_period_count) - 8'h01 && interval_count == $past(interval_count)))
	else $error("base count did not step down by one");

	chk_led_cause: assert property (@(posedge aclk) disable iff (!aresetn)
		$changed(led_drive) |-> (tick_handler_select == CIT_SEL_MEASURE && measure_counter == WAKE_PRELOAD))
	else $error("led toggled without interval expiry");

	chk_press_range: assert property (@(posedge aclk) disable iff (!aresetn)
		press_count <= `CIT_TABLE_LAST)
	else $error("press counter beyond table");

	chk_press_step: assert property (@(posedge aclk) disable iff (!aresetn)
		(tick_event && press_now && tick_handler_select == CIT_SEL_COUNT && press_count < `CIT_TABLE_LAST)
		|=> press_count == $past(press_count) + 8'h01)
	else $error("press counter did not increment");

	chk_wake_offset: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(tick_handler_select == CIT_SEL_MEASURE) |-> measure_counter == 16'h0029)
	else $error("measure counter preload is not offset plus one");

endmodule : cit_timer

// *** bench/cit_key_model.sv ***
// key switch with pull-up and contact bounce, plus a log of indicator toggles
// assumes the key pin is sampled on rising aclk edges by the timer
`timescale 1ns/100ps
module cit_key_model
(
	// clock
	input wire logic aclk,
	// pins
	output logic key_input_pin,
	input wire logic led_drive
);
	longint cycle = 0;
	longint toggle_at[$];
	logic led_last = 1'b0;
	initial
	begin
		key_input_pin = 1'b1;
	end
	always @(posedge aclk)
	begin
		cycle <= cycle + 1;
		led_last <= led_drive;
		if (led_drive === ~led_last)
			toggle_at.push_back(cycle);
	end
	// short releases right after the first contact; the pull-up returns the line high on release
	task automatic press(input int bounces, input int hold);
		key_input_pin <= 1'b0;
		repeat (bounces)
		begin
			@(posedge aclk);
			key_input_pin <= 1'b1;
			@(posedge aclk);
			key_input_pin <= 1'b0;
		end
		repeat (hold) @(posedge aclk);
		key_input_pin <= 1'b1;
		@(posedge aclk);
	endtask : press
endmodule : cit_key_model

// *** bench/cit_timer_test.sv ***
// self-checking bench: registers, calibration, debounce, interval expiry of the timer
// assumes the design's own assertions sit in the design files; tick period shortened by SLOW_DIV
`timescale 1ns/100ps
`include "cit_regs.svh"
module cit_timer_test;
	localparam int SLOW_DIV = 2;
	localparam int TICK = 48 * SLOW_DIV;
	typedef struct {logic wr; logic [7:0] a; logic [31:0] d; logic [3:0] s; logic [31:0] exp; logic [1:0] resp;}
		cit_row_type;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_awready;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'h0;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_wready;
	logic [1:0] s_axi_bresp;
	logic s_axi_bvalid;
	logic s_axi_bready = 1'b0;
	logic [7:0] s_axi_araddr = 8'h00;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_arready;
	logic [31:0] s_axi_rdata;
	logic [1:0] s_axi_rresp;
	logic s_axi_rvalid;
	logic s_axi_rready = 1'b0;
	logic key_input_pin;
	logic led_drive;
	int fails = 0;
	int n_compared = 0;
	longint rel;
	longint t0;
	longint d;
	logic [31:0] v;
	logic [31:0] c;
	logic [1:0] r;
	cit_row_type rows [0:10] = '{
		'{1'b0, 8'h20, 32'h0, 4'h0, 32'h1, `CIT_RESP_OKAY},
		'{1'b0, 8'h3c, 32'h0, 4'h0, 32'h8, `CIT_RESP_OKAY},
		'{1'b1, 8'h20, 32'h2, 4'h1, 32'h0, `CIT_RESP_OKAY},
		'{1'b0, 8'h20, 32'h0, 4'h0, 32'h2, `CIT_RESP_OKAY},
		'{1'b1, 8'h24, 32'h55, 4'he, 32'h0, `CIT_RESP_OKAY},
		'{1'b0, 8'h24, 32'h0, 4'h0, 32'h2, `CIT_RESP_OKAY},
		'{1'b1, 8'h2c, 32'h12345678, 4'hf, 32'h0, `CIT_RESP_OKAY},
		'{1'b0, 8'h2c, 32'h0, 4'h0, 32'h78, `CIT_RESP_OKAY},
		'{1'b1, 8'h40, 32'h1, 4'hf, 32'h0, `CIT_RESP_SLVERR},
		'{1'b0, 8'h40, 32'h0, 4'h0, 32'h0, `CIT_RESP_SLVERR},
		'{1'b1, 8'h04, 32'hffffffff, 4'hf, 32'h0, `CIT_RESP_OKAY}};

	cit_timer #(.SLOW_DIV(SLOW_DIV)) dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .key_input_pin(key_input_pin),
		.led_drive(led_drive));
	cit_key_model kp (.aclk(aclk), .key_input_pin(key_input_pin), .led_drive(led_drive));

	always #50 aclk = ~aclk;

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic print_verdict();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : print_verdict

	// each task starts just after a rising edge and leaves one idle edge behind it
	task automatic axi_write(input logic [7:0] a, input logic [31:0] wd, input logic [3:0] s,
		output logic [1:0] resp);
		logic aw_left;
		logic w_left;
		aw_left = 1'b1;
		w_left = 1'b1;
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= wd;
		s_axi_wstrb <= s;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (aw_left || w_left)
		begin
			@(posedge aclk);
			if (aw_left && s_axi_awready === 1'b1)
			begin
				aw_left = 1'b0;
				s_axi_awvalid <= 1'b0;
			end
			if (w_left && s_axi_wready === 1'b1)
			begin
				w_left = 1'b0;
				s_axi_wvalid <= 1'b0;
			end
		end
		while (s_axi_bvalid !== 1'b1) @(posedge aclk);
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask : axi_write

	task automatic axi_read(input logic [7:0] a, output logic [31:0] rd_data, output logic [1:0] resp);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		rd_data = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask : axi_read

	initial
	begin
		#9000000;
		fails++;
		print_verdict();
	end

	initial
	begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		rel = kp.cycle;
		repeat (2) @(posedge aclk);
		axi_read(`CIT_ADDR_STATUS, v, r);
		check("status at reset", v & 32'h0007ffff, 32'h00010000);
		do axi_read(`CIT_ADDR_STATUS, v, r); while (v[16] !== 1'b0);
		axi_read(`CIT_ADDR_COUNTS, c, r);
		axi_read(`CIT_ADDR_MEASURE, v, r);
		check("measure count", {31'h0, v[15:0] >= 16'd52 && v[15:0] <= 16'd57}, 32'h1);
		// the first tick is seen TICK edges after release: one step per seven clocks on top of offset plus one
		check("wake offset", {16'h0, v[15:0]} - 32'((TICK - 1) / 7), 32'd41);
		check("calibration", {24'h0, c[23:16]}, 32'hff);
		check("base after load", {24'h0, c[7:0]}, 32'hfe);
		check("interval start", {24'h0, c[15:8]}, 32'h1);
		repeat (TICK) @(posedge aclk);
		axi_read(`CIT_ADDR_COUNTS, c, r);
		check("base countdown", {24'h0, c[7:0]}, 32'hfd);
		foreach (rows[i])
		begin
			if (rows[i].wr)
				axi_write(rows[i].a, rows[i].d, rows[i].s, r);
			else
				axi_read(rows[i].a, v, r);
			if (!rows[i].wr)
				check("read data", v, rows[i].exp);
			check("response", {30'h0, r}, {30'h0, rows[i].resp});
		end
		// a second press while waiting must not restart the wait
		t0 = kp.cycle;
		fork
			begin
				kp.press(2, 4 * TICK);
				repeat (TICK) @(posedge aclk);
				kp.press(0, 9 * TICK);
			end
		join_none
		repeat (10) @(posedge aclk);
		axi_read(`CIT_ADDR_STATUS, v, r);
		check("debounce armed", {31'h0, v[17] === 1'b1 && v[15:8] >= 8'h08}, 32'h1);
		do axi_read(`CIT_ADDR_STATUS, v, r); while (v[7:0] !== 8'h01 && kp.cycle - t0 < 11 * TICK);
		d = kp.cycle - t0;
		check("press accepted", {24'h0, v[7:0]}, 32'h1);
		check("decision tick", {31'h0, d > 8 * TICK && d <= 9 * TICK + 12}, 32'h1);
		wait fork;
		kp.press(0, 3);
		repeat (10 * TICK) @(posedge aclk);
		axi_read(`CIT_ADDR_STATUS, v, r);
		check("released at decision", {14'h0, v[17:0]} & 32'h200ff, 32'h1);
		for (int k = 2; k <= 8; k++)
		begin
			kp.press(1, 10 * TICK);
			axi_read(`CIT_ADDR_STATUS, v, r);
			check("press count", {24'h0, v[7:0]}, 32'(k % 8));
		end
		while (kp.toggle_at.size() < 1) @(posedge aclk);
		axi_read(`CIT_ADDR_STATUS, v, r);
		check("led and reselect", {29'h0, v[18:16]}, 32'h5);
		axi_read(`CIT_ADDR_COUNTS, c, r);
		check("interval reload", {24'h0, c[15:8]}, 32'h2);
		d = kp.toggle_at[0] - rel - 255 * TICK;
		check("first expiry", {31'h0, d > -TICK && d < TICK}, 32'h1);
		while (kp.toggle_at.size() < 2) @(posedge aclk);
		d = kp.toggle_at[1] - kp.toggle_at[0] - 510 * TICK;
		check("second expiry", {31'h0, d > -TICK && d < TICK}, 32'h1);
		// a second reset mid-run must undo the table write and restore the first interval
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		axi_read(`CIT_ADDR_STATUS, v, r);
		check("status after reset", v & 32'h0007ffff, 32'h00010000);
		axi_read(`CIT_ADDR_TABLE, v, r);
		check("table after reset", v, 32'h1);
		axi_read(`CIT_ADDR_COUNTS, c, r);
		check("interval after reset", {24'h0, c[15:8]}, 32'h1);
		print_verdict();
	end
endmodule : cit_timer_test
